// ### mixvol_pkg.sv
package mixvol_pkg;

   // Clock and zero-cross timeout timing
   localparam int CLK_HZ = 125_000_000;
   localparam int TIMEOUT_RATE_SLOW_HZ = 31;
   localparam int TIMEOUT_RATE_FAST_HZ = 47;
   localparam int TIMEOUT_CYC_SLOW = CLK_HZ / TIMEOUT_RATE_SLOW_HZ;
   localparam int TIMEOUT_CYC_FAST = CLK_HZ / TIMEOUT_RATE_FAST_HZ;
   localparam int TICK_CNT_W = 23;

   // Register port and register indices; byte address is four times the index
   localparam int ADDR_W = 8;
   localparam int DATA_W = 9;
   localparam int IDX_OUT_EN = 3;
   localparam int IDX_EXTRA = 7;
   localparam int IDX_SPK_MIX = 50;
   localparam int IDX_SPK_VOL = 54;
   localparam int IDX_MONO_MIX = 56;
   localparam int IDX_STATUS = 63;
   localparam logic [7:0] ADDR_OUT_EN = 8'(IDX_OUT_EN * 4);
   localparam logic [7:0] ADDR_EXTRA = 8'(IDX_EXTRA * 4);
   localparam logic [7:0] ADDR_SPK_MIX = 8'(IDX_SPK_MIX * 4);
   localparam logic [7:0] ADDR_SPK_VOL = 8'(IDX_SPK_VOL * 4);
   localparam logic [7:0] ADDR_MONO_MIX = 8'(IDX_MONO_MIX * 4);
   localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

   // Field positions
   localparam int OE_SINGLE_BIT = 7;
   localparam int OE_SPK_NEG_BIT = 6;
   localparam int OE_SPK_POS_BIT = 5;
   localparam int OE_SINGLE_MIX_BIT = 3;
   localparam int OE_SPK_MIX_BIT = 2;
   localparam int EXTRA_SLOW_BIT = 0;
   localparam int EXTRA_RATE_BIT = 1;
   localparam int MIX_AUX_SPK_BIT = 5;
   localparam int MIX_AUX_SINGLE_BIT = 2;
   localparam int MIX_BYP_BIT = 1;
   localparam int MIX_DAC_BIT = 0;
   localparam int VOL_CUT_BIT = 8;
   localparam int VOL_ZC_BIT = 7;
   localparam int VOL_MUTE_BIT = 6;
   localparam int SINGLE_CUT_BIT = 7;
   localparam int SINGLE_MUTE_BIT = 6;
   localparam int STAT_PEND_BIT = 8;

   // Gain law: code 0x3F is +6 dB, 1 dB per step, 6 steps per halving
   localparam logic [5:0] GAIN_MAX = 6'h3f;
   localparam logic [5:0] GAIN_RST = 6'h39;
   localparam logic [5:0] STEPS_PER_HALF = 6'h06;
   localparam int GAIN_FRAC_W = 13;
   localparam logic signed [14:0] GMUL0 = 15'h2000;
   localparam logic signed [14:0] GMUL1 = 15'h1c85;
   localparam logic signed [14:0] GMUL2 = 15'h196b;
   localparam logic signed [14:0] GMUL3 = 15'h16a7;
   localparam logic signed [14:0] GMUL4 = 15'h1431;
   localparam logic signed [14:0] GMUL5 = 15'h11ff;
   // Bypass cut of 10 dB as 81/256
   localparam logic signed [8:0] BYP_CUT_NUM = 9'h051;
   localparam int BYP_CUT_SHIFT = 8;

   // Samples: two's complement, midpoint level is code zero
   localparam int SW = 16;
   localparam logic signed [15:0] MIDPOINT = 16'h0000;
   localparam logic signed [15:0] SAMPLE_MAX = 16'h7fff;
   localparam logic signed [15:0] SAMPLE_MIN = 16'h8001;

   typedef struct packed {
      logic signed [15:0] dac;
      logic signed [15:0] byp;
      logic signed [15:0] aux;
   } src_t;

   typedef struct packed {
      logic single_out_enable;
      logic spk_neg_en;
      logic spk_pos_en;
      logic single_mix_en;
      logic spk_mix_en;
      logic slow_tick_enable;
      logic rate_fast;
      logic aux_to_speaker_sel;
      logic bypass_to_speaker_sel;
      logic dac_to_speaker_sel;
      logic speaker_bypass_cut;
      logic speaker_zero_cross_en;
      logic speaker_silence;
      logic [5:0] speaker_gain_code;
      logic single_bypass_cut;
      logic single_out_silence;
      logic aux_to_single_sel;
      logic bypass_to_single_sel;
      logic dac_to_single_sel;
   } regs_t;

   localparam regs_t REGS_RST = '{speaker_silence: 1'b1, speaker_gain_code: GAIN_RST,
                                  default: '0};

   typedef enum logic [1:0] {
      GAIN_IDLE = 2'b01,
      GAIN_PEND = 2'b10
   } gain_st_t;

   typedef struct packed {
      logic [22:0] cnt;
      logic tick;
   } tick_st_t;

endpackage

// ### output_mixer_volume_control.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module output_mixer_volume_control
   import mixvol_pkg::*;
#(
   parameter int TIMEOUT_CYC_SLOW_P = TIMEOUT_CYC_SLOW,
   parameter int TIMEOUT_CYC_FAST_P = TIMEOUT_CYC_FAST
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [8:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [8:0] rdata,
   // Source samples
   input wire src_t src,
   input wire logic sample_valid,
   // Output samples and stage enables
   output logic signed [15:0] speaker_out_pos,
   output logic signed [15:0] speaker_out_neg,
   output logic signed [15:0] single_out_pin,
   output logic speaker_pos_active,
   output logic speaker_neg_active,
   output logic single_out_active,
   // Shared slow tick for the jack debounce
   output logic slow_tick
);

   typedef struct packed {
      regs_t r;
      logic [5:0] active_gain;
      gain_st_t gst;
      logic last_neg;
      logic signed [15:0] pos;
      logic signed [15:0] neg;
      logic signed [15:0] single;
      logic [8:0] rdata;
   } st_t;

   localparam st_t ST_RST = '{r: REGS_RST, active_gain: GAIN_RST, gst: GAIN_IDLE,
                              default: '0};

   st_t s_reg;
   st_t s_next;
   logic tick;
   logic wr_vol;
   logic zc_hit;
   logic signed [17:0] spk_mix;
   logic signed [17:0] single_mix;
   logic signed [15:0] spk_level;

   // Sum of selected sources, bypass optionally cut by 10 dB
   function automatic logic signed [17:0] sum3(input src_t x, input logic a_sel,
                                                input logic b_sel, input logic d_sel,
                                                input logic cut);
      logic signed [24:0] b;
      logic signed [17:0] acc;
      b = 25'(x.byp);
      if (cut) begin
         b = (25'(x.byp) * 25'(BYP_CUT_NUM)) >>> BYP_CUT_SHIFT;
      end
      acc = '0;
      if (d_sel) begin
         acc = acc + 18'(x.dac);
      end
      if (b_sel) begin
         acc = acc + 18'(b);
      end
      if (a_sel) begin
         acc = acc + 18'(x.aux);
      end
      return acc;
   endfunction

   // Gain: halve per six steps below +6 dB, fine steps from a table
   function automatic logic signed [15:0] apply_gain(input logic signed [17:0] x,
                                                      input logic [5:0] code);
      logic [5:0] a;
      logic [3:0] sh;
      logic [2:0] fr;
      logic signed [14:0] m;
      logic signed [33:0] p;
      a = GAIN_MAX - code;
      sh = 4'(a / STEPS_PER_HALF);
      fr = 3'(a % STEPS_PER_HALF);
      case (fr)
         3'h0: m = GMUL0;
         3'h1: m = GMUL1;
         3'h2: m = GMUL2;
         3'h3: m = GMUL3;
         3'h4: m = GMUL4;
         3'h5: m = GMUL5;
         default: m = GMUL0;
      endcase
      // One bit less of shift: the table's unity entry then means x2 at the top code
      p = (34'(x) * 34'(m)) >>> (GAIN_FRAC_W - 1 + int'(sh));
      // Clip symmetric so the inverted output never overflows
      if (p > 34'(SAMPLE_MAX)) begin
         return SAMPLE_MAX;
      end else if (p < 34'(SAMPLE_MIN)) begin
         return SAMPLE_MIN;
      end
      return 16'(p);
   endfunction

   // Timeout tick; held in reset while the enable bit is clear
   slow_tick_gen #(
      .CYC_SLOW(TIMEOUT_CYC_SLOW_P),
      .CYC_FAST(TIMEOUT_CYC_FAST_P)
   ) u_tick (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .enable(s_reg.r.slow_tick_enable),
      .rate_fast(s_reg.r.rate_fast),
      .tick(tick)
   );

   // Mixer sums
   assign spk_mix = sum3(src, s_reg.r.aux_to_speaker_sel, s_reg.r.bypass_to_speaker_sel,
                         s_reg.r.dac_to_speaker_sel, s_reg.r.speaker_bypass_cut);
   assign single_mix = sum3(src, s_reg.r.aux_to_single_sel, s_reg.r.bypass_to_single_sel,
                            s_reg.r.dac_to_single_sel, s_reg.r.single_bypass_cut);
   assign spk_level = apply_gain(spk_mix, s_reg.active_gain);
   assign wr_vol = wr_en && (addr == ADDR_SPK_VOL);
   // A crossing is a sign change between consecutive speaker mixer samples
   assign zc_hit = sample_valid && (spk_mix[17] != s_reg.last_neg);

   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.rdata = '0;
      // Register writes, every field of the word at once
      if (wr_en) begin
         case (addr)
            ADDR_OUT_EN: begin
               s_next.r.single_out_enable = wdata[OE_SINGLE_BIT];
               s_next.r.spk_neg_en = wdata[OE_SPK_NEG_BIT];
               s_next.r.spk_pos_en = wdata[OE_SPK_POS_BIT];
               s_next.r.single_mix_en = wdata[OE_SINGLE_MIX_BIT];
               s_next.r.spk_mix_en = wdata[OE_SPK_MIX_BIT];
            end
            ADDR_EXTRA: begin
               s_next.r.slow_tick_enable = wdata[EXTRA_SLOW_BIT];
               s_next.r.rate_fast = wdata[EXTRA_RATE_BIT];
            end
            ADDR_SPK_MIX: begin
               s_next.r.aux_to_speaker_sel = wdata[MIX_AUX_SPK_BIT];
               s_next.r.bypass_to_speaker_sel = wdata[MIX_BYP_BIT];
               s_next.r.dac_to_speaker_sel = wdata[MIX_DAC_BIT];
            end
            ADDR_SPK_VOL: begin
               s_next.r.speaker_bypass_cut = wdata[VOL_CUT_BIT];
               s_next.r.speaker_zero_cross_en = wdata[VOL_ZC_BIT];
               s_next.r.speaker_silence = wdata[VOL_MUTE_BIT];
               s_next.r.speaker_gain_code = wdata[5:0];
            end
            ADDR_MONO_MIX: begin
               s_next.r.single_bypass_cut = wdata[SINGLE_CUT_BIT];
               s_next.r.single_out_silence = wdata[SINGLE_MUTE_BIT];
               s_next.r.aux_to_single_sel = wdata[MIX_AUX_SINGLE_BIT];
               s_next.r.bypass_to_single_sel = wdata[MIX_BYP_BIT];
               s_next.r.dac_to_single_sel = wdata[MIX_DAC_BIT];
            end
            default: begin
               s_next.r = s_reg.r;
            end
         endcase
      end
      // Read data: undefined bits and unmapped addresses give zero
      if (rd_en) begin
         case (addr)
            ADDR_OUT_EN: begin
               s_next.rdata[OE_SINGLE_BIT] = s_reg.r.single_out_enable;
               s_next.rdata[OE_SPK_NEG_BIT] = s_reg.r.spk_neg_en;
               s_next.rdata[OE_SPK_POS_BIT] = s_reg.r.spk_pos_en;
               s_next.rdata[OE_SINGLE_MIX_BIT] = s_reg.r.single_mix_en;
               s_next.rdata[OE_SPK_MIX_BIT] = s_reg.r.spk_mix_en;
            end
            ADDR_EXTRA: begin
               s_next.rdata[EXTRA_SLOW_BIT] = s_reg.r.slow_tick_enable;
               s_next.rdata[EXTRA_RATE_BIT] = s_reg.r.rate_fast;
            end
            ADDR_SPK_MIX: begin
               s_next.rdata[MIX_AUX_SPK_BIT] = s_reg.r.aux_to_speaker_sel;
               s_next.rdata[MIX_BYP_BIT] = s_reg.r.bypass_to_speaker_sel;
               s_next.rdata[MIX_DAC_BIT] = s_reg.r.dac_to_speaker_sel;
            end
            ADDR_SPK_VOL: begin
               s_next.rdata[VOL_CUT_BIT] = s_reg.r.speaker_bypass_cut;
               s_next.rdata[VOL_ZC_BIT] = s_reg.r.speaker_zero_cross_en;
               s_next.rdata[VOL_MUTE_BIT] = s_reg.r.speaker_silence;
               s_next.rdata[5:0] = s_reg.r.speaker_gain_code;
            end
            ADDR_MONO_MIX: begin
               s_next.rdata[SINGLE_CUT_BIT] = s_reg.r.single_bypass_cut;
               s_next.rdata[SINGLE_MUTE_BIT] = s_reg.r.single_out_silence;
               s_next.rdata[MIX_AUX_SINGLE_BIT] = s_reg.r.aux_to_single_sel;
               s_next.rdata[MIX_BYP_BIT] = s_reg.r.bypass_to_single_sel;
               s_next.rdata[MIX_DAC_BIT] = s_reg.r.dac_to_single_sel;
            end
            ADDR_STATUS: begin
               s_next.rdata[STAT_PEND_BIT] = (s_reg.gst == GAIN_PEND);
               s_next.rdata[5:0] = s_reg.active_gain;
            end
            default: begin
               s_next.rdata = '0;
            end
         endcase
      end
      // Gain transfer: immediate, or held until a crossing or a tick
      case (s_reg.gst)
         GAIN_IDLE: begin
            if (wr_vol) begin
               if (s_next.r.speaker_zero_cross_en) begin
                  s_next.gst = GAIN_PEND;
               end else begin
                  s_next.active_gain = s_next.r.speaker_gain_code;
               end
            end
         end
         GAIN_PEND: begin
            // Clearing the enable also releases the held code at once
            if (zc_hit || tick || !s_next.r.speaker_zero_cross_en) begin
               s_next.active_gain = s_next.r.speaker_gain_code;
               s_next.gst = GAIN_IDLE;
            end
         end
         default: begin
            s_next.gst = GAIN_IDLE;
         end
      endcase
      // Output samples, updated once per input sample
      if (sample_valid) begin
         s_next.last_neg = spk_mix[17];
         // Mute and disabled stages hold the same midpoint, so no step
         if (s_reg.r.speaker_silence || !s_reg.r.spk_mix_en) begin
            s_next.pos = MIDPOINT;
         end else begin
            s_next.pos = spk_level;
         end
         s_next.neg = -s_next.pos;
         if (s_reg.r.single_out_silence || !s_reg.r.single_mix_en) begin
            s_next.single = MIDPOINT;
         end else begin
            s_next.single = apply_gain(single_mix, GAIN_RST);
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= ST_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs; a disabled stage sits at the midpoint level
   assign rdata = s_reg.rdata;
   assign speaker_pos_active = s_reg.r.spk_pos_en;
   assign speaker_neg_active = s_reg.r.spk_neg_en;
   assign single_out_active = s_reg.r.single_out_enable;
   assign speaker_out_pos = s_reg.r.spk_pos_en ? s_reg.pos : MIDPOINT;
   assign speaker_out_neg = s_reg.r.spk_neg_en ? s_reg.neg : MIDPOINT;
   assign single_out_pin = s_reg.r.single_out_enable ? s_reg.single : MIDPOINT;
   assign slow_tick = tick;

   // Checks
   property p_mute_mid;
      @(posedge clk_sys) disable iff (!rst_b)
      sample_valid && s_reg.r.speaker_silence |=> s_reg.pos == MIDPOINT && s_reg.neg == MIDPOINT;
   endproperty
   a_mute_mid: assert property (p_mute_mid) else $error("speaker not at midpoint");

   property p_bridge;
      @(posedge clk_sys) disable iff (!rst_b)
      s_reg.neg == -s_reg.pos;
   endproperty
   a_bridge: assert property (p_bridge) else $error("speaker pair not inverted");

   property p_immediate;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_vol && !wdata[VOL_ZC_BIT] && s_reg.gst == GAIN_IDLE
      |=> s_reg.active_gain == $past(wdata[5:0]) && s_reg.gst == GAIN_IDLE;
   endproperty
   a_immediate: assert property (p_immediate) else $error("gain not applied at once");

   property p_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_vol && wdata[VOL_ZC_BIT] && s_reg.gst == GAIN_IDLE
      |=> s_reg.gst == GAIN_PEND && s_reg.active_gain == $past(s_reg.active_gain);
   endproperty
   a_hold: assert property (p_hold) else $error("zero-cross gain not held");

   property p_tick_apply;
      @(posedge clk_sys) disable iff (!rst_b)
      s_reg.gst == GAIN_PEND && tick && !wr_en
      |=> s_reg.gst == GAIN_IDLE && s_reg.active_gain == s_reg.r.speaker_gain_code;
   endproperty
   a_tick_apply: assert property (p_tick_apply) else $error("timeout did not apply gain");

   property p_no_tick;
      @(posedge clk_sys) disable iff (!rst_b)
      !s_reg.r.slow_tick_enable ##1 !s_reg.r.slow_tick_enable |-> !tick;
   endproperty
   a_no_tick: assert property (p_no_tick) else $error("tick while slow clock off");

   property p_single_off;
      @(posedge clk_sys) disable iff (!rst_b)
      !s_reg.r.single_out_enable |-> single_out_pin == MIDPOINT && !single_out_active;
   endproperty
   a_single_off: assert property (p_single_off) else $error("mono driven while off");

   property p_single_mute;
      @(posedge clk_sys) disable iff (!rst_b)
      sample_valid && s_reg.r.single_out_silence |=> s_reg.single == MIDPOINT;
   endproperty
   a_single_mute: assert property (p_single_mute) else $error("mono mute not at midpoint");

   property p_unity;
      @(posedge clk_sys) disable iff (!rst_b)
      sample_valid && s_reg.r.spk_mix_en && !s_reg.r.speaker_silence
      && s_reg.active_gain == GAIN_RST && s_reg.r.dac_to_speaker_sel
      && !s_reg.r.bypass_to_speaker_sel && !s_reg.r.aux_to_speaker_sel && src.dac != 16'h8000
      |=> s_reg.pos == $past(src.dac);
   endproperty
   a_unity: assert property (p_unity) else $error("0 dB code not unity");

   property p_readback;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_en && addr == ADDR_SPK_MIX ##1 !wr_en ##1 rd_en && addr == ADDR_SPK_MIX
      |=> rdata == ($past(wdata, 3) & 9'h023);
   endproperty
   a_readback: assert property (p_readback) else $error("mixer select readback wrong");

   c_zc_apply: cover property (@(posedge clk_sys) disable iff (!rst_b)
      s_reg.gst == GAIN_PEND && zc_hit);
   c_tick_apply: cover property (@(posedge clk_sys) disable iff (!rst_b)
      s_reg.gst == GAIN_PEND && tick && !zc_hit);
   c_unmute: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(s_reg.r.speaker_silence));
   c_single_ref: cover property (@(posedge clk_sys) disable iff (!rst_b)
      s_reg.r.single_out_enable && s_reg.r.single_out_silence);

endmodule // output_mixer_volume_control

// ### output_mixer_volume_control_tb.sv
`timescale 1ns/1ps
module output_mixer_volume_control_tb;
   import mixvol_pkg::*;
   // Short timeout periods keep the run brief
   localparam int CYC_S = 20;
   localparam int CYC_F = 12;
   logic clk_sys, rst_b, wr_en, rd_en, sample_valid;
   logic [7:0] addr;
   logic [8:0] wdata, rdata;
   src_t src;
   logic signed [15:0] speaker_out_pos, speaker_out_neg, single_out_pin;
   logic speaker_pos_active, speaker_neg_active, single_out_active, slow_tick;
   int miscompares, samples_checked;

   output_mixer_volume_control #(.TIMEOUT_CYC_SLOW_P(CYC_S), .TIMEOUT_CYC_FAST_P(CYC_F))
      u_output_mixer_volume_control (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src(src),
      .sample_valid(sample_valid), .speaker_out_pos(speaker_out_pos),
      .speaker_out_neg(speaker_out_neg), .single_out_pin(single_out_pin),
      .speaker_pos_active(speaker_pos_active), .speaker_neg_active(speaker_neg_active),
      .single_out_active(single_out_active), .slow_tick(slow_tick));

   // 125 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic results();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // Bus cycles change signals right after the edge, one strobe cycle each
   task automatic wr(input logic [7:0] a, input logic [8:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk("rdata", {7'h00, e}, {7'h00, rdata});
   endtask

   // One sample in; outputs are looked at one cycle later
   task automatic smp(input logic [15:0] d, input logic [15:0] b, input logic [15:0] x);
      @(posedge clk_sys);
      src <= '{dac: d, byp: b, aux: x};
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      #1;
   endtask

   // Counts edges up to the next tick; a missing tick ends the run
   task automatic wait_tick(output int n);
      n = 0;
      while (n < 60) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (slow_tick === 1'b1) return;
      end
      chk("slow_tick_wait", 16'h0001, 16'h0000);
      results();
   endtask

   task automatic t_reset();
      chk("pos_active", 16'h0000, {15'h0000, speaker_pos_active});
      chk("single_active", 16'h0000, {15'h0000, single_out_active});
      chk("speaker_out_pos", 16'h0000, speaker_out_pos);
      rd(ADDR_OUT_EN, 9'h000);
      rd(ADDR_EXTRA, 9'h000);
      rd(ADDR_SPK_MIX, 9'h000);
      rd(ADDR_SPK_VOL, 9'h079);
      rd(ADDR_MONO_MIX, 9'h000);
      rd(8'h10, 9'h000);
   endtask

   task automatic t_speaker();
      wr(ADDR_OUT_EN, 9'h0ec);
      wr(ADDR_SPK_VOL, 9'h039);
      wr(ADDR_SPK_MIX, 9'h001);
      smp(16'd1000, 16'd256, 16'd10);
      chk("speaker_out_pos", 16'd1000, speaker_out_pos);
      chk("speaker_out_neg", 16'(-1000), speaker_out_neg);
      chk("neg_active", 16'h0001, {15'h0000, speaker_neg_active});
      wr(ADDR_SPK_MIX, 9'h002);
      smp(16'd1000, 16'd256, 16'd10);
      chk("speaker_out_pos", 16'd256, speaker_out_pos);
      wr(ADDR_SPK_MIX, 9'h020);
      smp(16'd1000, 16'd256, 16'd10);
      chk("speaker_out_pos", 16'd10, speaker_out_pos);
      wr(ADDR_SPK_VOL, 9'h139);
      wr(ADDR_SPK_MIX, 9'h023);
      rd(ADDR_SPK_MIX, 9'h023);
      smp(16'd1000, 16'd256, 16'd10);
      chk("speaker_out_pos", 16'd1091, speaker_out_pos);
      wr(ADDR_SPK_MIX, 9'h001);
      wr(ADDR_SPK_VOL, 9'h03f);
      smp(16'd1000, 16'd0, 16'd0);
      chk("speaker_out_pos", 16'd2000, speaker_out_pos);
      wr(ADDR_SPK_VOL, 9'h033);
      smp(16'd1000, 16'd0, 16'd0);
      chk("speaker_out_pos", 16'd500, speaker_out_pos);
      wr(ADDR_SPK_VOL, 9'h07f);
      smp(16'd1000, 16'd0, 16'd0);
      chk("speaker_out_pos", 16'h0000, speaker_out_pos);
      chk("speaker_out_neg", 16'h0000, speaker_out_neg);
      wr(ADDR_SPK_VOL, 9'h03f);
      smp(16'd1000, 16'd0, 16'd0);
      chk("speaker_out_pos", 16'd2000, speaker_out_pos);
   endtask

   // Gain held until the mix changes sign
   task automatic t_zero_cross();
      wr(ADDR_SPK_VOL, 9'h0b9);
      rd(ADDR_STATUS, 9'h13f);
      smp(16'd1000, 16'd0, 16'd0);
      chk("speaker_out_pos", 16'd2000, speaker_out_pos);
      smp(16'(-1000), 16'd0, 16'd0);
      rd(ADDR_STATUS, 9'h039);
      smp(16'(-1000), 16'd0, 16'd0);
      chk("speaker_out_pos", 16'(-1000), speaker_out_pos);
   endtask

   // No crossing arrives: the slow tick forces the change
   task automatic t_timeout();
      int n;
      wr(ADDR_SPK_VOL, 9'h0bf);
      wr(ADDR_EXTRA, 9'h001);
      rd(ADDR_STATUS, 9'h139);
      wait_tick(n);
      @(posedge clk_sys);
      #1;
      rd(ADDR_STATUS, 9'h03f);
      wait_tick(n);
      wait_tick(n);
      chk("slow_period", 16'(CYC_S), 16'(n));
      wr(ADDR_EXTRA, 9'h000);
      wr(ADDR_EXTRA, 9'h003);
      rd(ADDR_EXTRA, 9'h003);
      wait_tick(n);
      wait_tick(n);
      chk("fast_period", 16'(CYC_F), 16'(n));
      wr(ADDR_EXTRA, 9'h000);
   endtask

   task automatic t_mono();
      wr(ADDR_MONO_MIX, 9'h007);
      smp(16'd100, 16'd256, 16'd10);
      chk("single_out_pin", 16'd366, single_out_pin);
      chk("single_active", 16'h0001, {15'h0000, single_out_active});
      wr(ADDR_MONO_MIX, 9'h082);
      smp(16'd100, 16'd256, 16'd10);
      chk("single_out_pin", 16'd81, single_out_pin);
      wr(ADDR_MONO_MIX, 9'h0c2);
      rd(ADDR_MONO_MIX, 9'h0c2);
      smp(16'd100, 16'd256, 16'd10);
      chk("single_out_pin", 16'h0000, single_out_pin);
      wr(ADDR_MONO_MIX, 9'h002);
      wr(ADDR_OUT_EN, 9'h000);
      smp(16'd100, 16'd256, 16'd10);
      chk("single_active", 16'h0000, {15'h0000, single_out_active});
      chk("single_out_pin", 16'h0000, single_out_pin);
      chk("pos_active", 16'h0000, {15'h0000, speaker_pos_active});
   endtask

   // Main sequence: reset held five cycles, then each scenario
   initial begin
      miscompares = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      sample_valid = 1'b0;
      addr = 8'h00;
      wdata = 9'h000;
      src = '0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      t_reset();
      t_speaker();
      t_zero_cross();
      t_timeout();
      t_mono();
      results();
   end
endmodule // output_mixer_volume_control_tb

// ### slow_tick_gen.sv
`timescale 1ns/1ps
module slow_tick_gen
   import mixvol_pkg::*;
#(
   parameter int CYC_SLOW = TIMEOUT_CYC_SLOW,
   parameter int CYC_FAST = TIMEOUT_CYC_FAST
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control
   input wire logic enable,
   input wire logic rate_fast,
   // One-cycle tick at the timeout rate
   output logic tick
);

   tick_st_t s_reg;
   tick_st_t s_next;
   logic [22:0] last;

   // Counter restarts whenever disabled, so the first tick is a full period away
   always_comb begin
      s_next = s_reg;
      last = rate_fast ? TICK_CNT_W'(CYC_FAST - 1) : TICK_CNT_W'(CYC_SLOW - 1);
      s_next.tick = 1'b0;
      if (!enable) begin
         s_next.cnt = '0;
      end else if (s_reg.cnt >= last) begin
         s_next.cnt = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 23'h00_0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule // slow_tick_gen
